// ---- pkg/pcd_pkg.sv ----
// Purpose: shared constants for the clock divider and regulator wake block
// Assumes: 32-bit AXI4-Lite register bus, one clock (core_clk, 40 MHz)
// Notes:   byte offsets, field positions and reset values live here, except the sdram / async echo enable resets
package pcd_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PCD_OFS_PLLCTL = 8'h00;  // multiplier, bypass, apply
  localparam logic [7:0] PCD_OFS_DIV    = 8'h04;  // system and core dividers
  localparam logic [7:0] PCD_OFS_MEMCTL = 8'h08;  // sdram / async echo enables
  localparam logic [7:0] PCD_OFS_VRCTL  = 8'h0c;  // regulator control
  localparam logic [7:0] PCD_OFS_STAT   = 8'h10;  // read-only status

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int         PCD_MULT_W    = 7;
  localparam logic [6:0] PCD_MULT_RST  = 7'h06;   // multiplier after reset
  localparam logic [6:0] PCD_MULT_MIN  = 7'h05;
  localparam logic [6:0] PCD_MULT_MAX  = 7'h40;
  localparam int         PCD_BYP_BIT   = 8;
  localparam int         PCD_APPLY_BIT = 9;
  localparam int         PCD_CDF_LSB   = 4;       // core divider field position
  localparam logic [3:0] PCD_SSEL_RST  = 4'h5;    // system divider after reset
  localparam logic [1:0] PCD_CDF_RST   = 2'h0;    // core divider after reset
  localparam logic [3:0] PCD_CDIV_RST  = 4'h1;    // core ratio for that code
  localparam logic [1:0] PCD_REGF_RST  = 2'h3;    // regulator field after reset
  localparam logic [1:0] PCD_REGF_OFF  = 2'h0;    // value that shuts regulator
  localparam int         PCD_SDRAM_BIT = 0;       // memory control echo enables
  localparam int         PCD_ASYNC_BIT = 1;
  localparam int         PCD_LOCK_BIT  = 8;       // status bit positions
  localparam int         PCD_WAKE_BIT  = 9;
  localparam int         PCD_RUN_BIT   = 10;
  localparam int         PCD_PGOOD_BIT = 11;
  localparam logic [1:0] PCD_RESP_OK   = 2'h0;
  localparam logic [1:0] PCD_RESP_SLV  = 2'h2;    // unmapped address answer

  // ----------------------------------------------------------------
  // state of the pll relock sequence
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    PCD_LOCKED  = 1'b0,
    PCD_RELOCK  = 1'b1
  } pcd_pll_e;

endpackage : pcd_pkg

// ---- rtl/pcd_clock_ctl.sv ----
// Purpose: clock dividers, pll multiplier control, clock echo outputs and
//          external regulator wake / power-good handling
// Assumes: core_clk stands for the vco clock; divided clocks leave as
//          one-cycle enable ticks; clock_input is sampled on core_clk
// Notes:   registers reached over AXI4-Lite
module pcd_clock_ctl
  import pcd_pkg::*;
#(
  parameter int LOCK_CYCLES = 512                  // pll relock interval
) (
  input  wire logic        core_clk,               // vco reference clock
  input  wire logic        arst_n,                 // async reset, active low
  input  wire logic [7:0]  s_axi_awaddr,           // write address
  input  wire logic        s_axi_awvalid,          // write address valid
  output logic             s_axi_awready,          // write address ready
  input  wire logic [31:0] s_axi_wdata,            // write data
  input  wire logic [3:0]  s_axi_wstrb,            // write strobes
  input  wire logic        s_axi_wvalid,           // write data valid
  output logic             s_axi_wready,           // write data ready
  output logic [1:0]       s_axi_bresp,            // write response
  output logic             s_axi_bvalid,           // write response valid
  input  wire logic        s_axi_bready,           // write response ready
  input  wire logic [7:0]  s_axi_araddr,           // read address
  input  wire logic        s_axi_arvalid,          // read address valid
  output logic             s_axi_arready,          // read address ready
  output logic [31:0]      s_axi_rdata,            // read data
  output logic [1:0]       s_axi_rresp,            // read response
  output logic             s_axi_rvalid,           // read data valid
  input  wire logic        s_axi_rready,           // read data ready
  input  wire logic        clock_input,            // sampled input clock
  input  wire logic        power_good_n,           // supply good, active low
  output logic             buffered_clock_out,     // copy of input clock
  output logic             core_clock,             // core clock tick
  output logic             sysclk_tick,            // peripheral clock tick
  output logic             sysclk_echo_out,        // system clock echo pin
  output logic             regulator_wake_out,     // regulator power request
  output logic             device_run,             // core may start
  output logic [6:0]       pll_mult                // active multiplier
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       awrdy;
    logic       aw_got;
    logic [7:0] awaddr;
    logic       wrdy;
    logic       w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arrdy;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [6:0] mult;
    logic [6:0] mult_pend;
    logic       bypass;
    pcd_pll_e   pll;
    logic [15:0] lock_cnt;
    logic [3:0] ssel;
    logic [1:0] cdf;
    logic [3:0] sdiv;      // system ratio in use
    logic [3:0] cdiv;      // core ratio in use
    logic [3:0] scnt;
    logic [3:0] ccnt;
    logic       sdram_en;
    logic       async_en;
    logic [1:0] regf;
    logic       in_clk_q;
    logic       bufclk;
    logic       ctick;
    logic       stick;
    logic       echo;
    logic       wake;
    logic       run;
  } pcd_state_s;

  pcd_state_s s_q;
  pcd_state_s s_d;

  // core ratio code to divisor
  function automatic logic [3:0] core_ratio(input logic [1:0] code);
    case (code)
      2'h0:    core_ratio = 4'h1;
      2'h1:    core_ratio = 4'h2;
      2'h2:    core_ratio = 4'h4;
      default: core_ratio = 4'h8;
    endcase
  endfunction : core_ratio

  // advance a divider counter; tick on wrap, reload ratio at the wrap
  function automatic logic [4:0] div_step(input logic [3:0] cnt,
                                          input logic [3:0] div);
    if (cnt >= div - 4'h1) begin
      div_step = 5'h10;
    end else begin
      div_step = {1'b0, cnt + 4'h1};
    end
  endfunction : div_step

  localparam logic [15:0] LOCK_LAST = 16'(LOCK_CYCLES - 1);

  logic       aw_take;
  logic       w_take;
  logic       do_wr;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [4:0] sstep;
  logic [4:0] cstep;
  logic       in_rise;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d     = s_q;
    aw_take = s_axi_awvalid & s_q.awrdy;
    w_take  = s_axi_wvalid & s_q.wrdy;
    wa      = s_q.aw_got ? s_q.awaddr : s_axi_awaddr;
    wd      = s_q.w_got ? s_q.wdata : s_axi_wdata;
    do_wr   = (s_q.aw_got | aw_take) & (s_q.w_got | w_take) & ~s_q.bvalid;
    in_rise = clock_input & ~s_q.in_clk_q;
    sstep   = div_step(s_q.scnt, s_q.sdiv);
    cstep   = div_step(s_q.ccnt, s_q.cdiv);

    // write channel capture
    if (aw_take) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
      s_d.awrdy  = 1'b0;
    end
    if (w_take) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
      s_d.wrdy  = 1'b0;
    end

    // pll relock sequence
    if (s_q.pll == PCD_RELOCK) begin
      if (s_q.lock_cnt == LOCK_LAST) begin
        s_d.pll  = PCD_LOCKED;
        s_d.mult = s_q.mult_pend;
      end else begin
        s_d.lock_cnt = s_q.lock_cnt + 16'h1;
      end
    end

    // register writes
    if (do_wr) begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = PCD_RESP_OK;
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      if ((s_q.w_got ? s_q.wstrb : s_axi_wstrb) != 4'h0) begin
        case (wa)
          PCD_OFS_PLLCTL: begin
            if (wd[6:0] >= PCD_MULT_MIN && wd[6:0] <= PCD_MULT_MAX) begin
              s_d.mult_pend = wd[6:0];
            end
            s_d.bypass = wd[PCD_BYP_BIT];
            if (wd[PCD_APPLY_BIT] && s_q.pll == PCD_LOCKED) begin
              s_d.pll      = PCD_RELOCK;
              s_d.lock_cnt = 16'h0;
            end
          end
          PCD_OFS_DIV: begin
            if (wd[3:0] != 4'h0) begin
              s_d.ssel = wd[3:0];
            end
            s_d.cdf = wd[PCD_CDF_LSB +: 2];
          end
          PCD_OFS_MEMCTL: begin
            s_d.sdram_en = wd[PCD_SDRAM_BIT];
            s_d.async_en = wd[PCD_ASYNC_BIT];
          end
          PCD_OFS_VRCTL: s_d.regf = wd[1:0];
          PCD_OFS_STAT: s_d.bresp = PCD_RESP_SLV;
          default: s_d.bresp = PCD_RESP_SLV;
        endcase
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.awrdy  = 1'b1;
      s_d.wrdy   = 1'b1;
    end

    // read channel
    if (s_axi_arvalid && s_q.arrdy) begin
      s_d.arrdy  = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp  = PCD_RESP_OK;
      s_d.rdata  = 32'h0;
      case (s_axi_araddr)
        PCD_OFS_PLLCTL: begin
          s_d.rdata[6:0]           = s_q.mult_pend;
          s_d.rdata[PCD_BYP_BIT]   = s_q.bypass;
        end
        PCD_OFS_DIV: begin
          s_d.rdata[3:0]                = s_q.ssel;
          s_d.rdata[PCD_CDF_LSB +: 2]   = s_q.cdf;
        end
        PCD_OFS_MEMCTL: begin
          s_d.rdata[PCD_SDRAM_BIT] = s_q.sdram_en;
          s_d.rdata[PCD_ASYNC_BIT] = s_q.async_en;
        end
        PCD_OFS_VRCTL:  s_d.rdata[1:0] = s_q.regf;
        PCD_OFS_STAT: begin
          s_d.rdata[6:0] = s_q.mult;
          s_d.rdata[PCD_LOCK_BIT]  = (s_q.pll == PCD_LOCKED);
          s_d.rdata[PCD_WAKE_BIT]  = s_q.wake;
          s_d.rdata[PCD_RUN_BIT]   = s_q.run;
          s_d.rdata[PCD_PGOOD_BIT] = ~power_good_n;
        end
        default: s_d.rresp = PCD_RESP_SLV;
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arrdy  = 1'b1;
    end

    // clock echo of input clock
    s_d.in_clk_q = clock_input;
    s_d.bufclk  = clock_input;

    // dividers: the ratio in use is reloaded only at a wrap
    s_d.scnt = sstep[3:0];
    s_d.ccnt = cstep[3:0];
    if (sstep[4]) begin
      s_d.sdiv = s_q.ssel;
    end
    if (cstep[4]) begin
      s_d.cdiv = core_ratio(s_q.cdf);
    end
    if (s_q.bypass) begin
      s_d.stick = in_rise;
      s_d.ctick = in_rise;
    end else begin
      s_d.stick = sstep[4];
      s_d.ctick = cstep[4];
    end
    s_d.echo = s_d.stick & (s_q.sdram_en | s_q.async_en);

    // regulator wake and power good
    s_d.wake = (s_q.regf != PCD_REGF_OFF);
    s_d.run  = s_q.wake & ~power_good_n;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q           <= '0;
      s_q.awrdy     <= 1'b1;
      s_q.wrdy      <= 1'b1;
      s_q.arrdy     <= 1'b1;
      s_q.mult      <= PCD_MULT_RST;
      s_q.mult_pend <= PCD_MULT_RST;
      s_q.pll       <= PCD_LOCKED;
      s_q.ssel      <= PCD_SSEL_RST;
      s_q.sdiv      <= PCD_SSEL_RST;
      s_q.cdf       <= PCD_CDF_RST;
      s_q.cdiv      <= PCD_CDIV_RST;
      s_q.sdram_en  <= 1'b1;
      s_q.async_en  <= 1'b1;
      s_q.regf      <= PCD_REGF_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign s_axi_awready      = s_q.awrdy;
  assign s_axi_wready       = s_q.wrdy;
  assign s_axi_bvalid       = s_q.bvalid;
  assign s_axi_bresp        = s_q.bresp;
  assign s_axi_arready      = s_q.arrdy;
  assign s_axi_rvalid       = s_q.rvalid;
  assign s_axi_rdata        = s_q.rdata;
  assign s_axi_rresp        = s_q.rresp;
  assign buffered_clock_out = s_q.bufclk;
  assign core_clock         = s_q.ctick;
  assign sysclk_tick        = s_q.stick;
  assign sysclk_echo_out    = s_q.echo;
  assign regulator_wake_out = s_q.wake;
  assign device_run         = s_q.run;
  assign pll_mult           = s_q.mult;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // regulator field decode and its registered wake output
  sequence s_regf_off;
    s_q.regf == PCD_REGF_OFF;
  endsequence
  sequence s_wake_low2;
    1'b1 ##1 !regulator_wake_out;
  endsequence
  property p_wake_off;
    s_regf_off |-> s_wake_low2;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake not low");
  property p_wake_on;
    (s_q.regf != PCD_REGF_OFF) |=> regulator_wake_out;
  endproperty
  a_wake_on: assert property (p_wake_on) else $error("wake not high");
  property p_run_pg;
    device_run |-> $past(!power_good_n);
  endproperty
  a_run_pg: assert property (p_run_pg) else $error("run without power good");
  property p_bufclk;
    ##1 1'b1 |-> buffered_clock_out == $past(clock_input);
  endproperty
  a_bufclk: assert property (p_bufclk) else $error("buffered clock mismatch");
  property p_mult_range;
    pll_mult >= PCD_MULT_MIN && pll_mult <= PCD_MULT_MAX;
  endproperty
  a_mult_range: assert property (p_mult_range) else $error("bad multiplier");
  property p_echo_off;
    (!s_q.sdram_en && !s_q.async_en) |=> !sysclk_echo_out;
  endproperty
  a_echo_off: assert property (p_echo_off) else $error("echo not disabled");
  property p_sys_ratio;
    (!s_q.bypass && s_q.sdiv == 4'h2 && sysclk_tick && $stable(s_q.bypass))
      |=> !sysclk_tick ##1 sysclk_tick;
  endproperty
  a_sys_ratio: assert property (p_sys_ratio) else $error("system ratio 2 broken");
  property p_core_one;
    (!s_q.bypass && s_q.cdiv == 4'h1 && s_q.ccnt == 4'h0) |=> core_clock;
  endproperty
  a_core_one: assert property (p_core_one) else $error("core ratio 1 broken");
  property p_reload_wrap;
    $changed(s_q.sdiv) |-> $past(s_q.scnt) >= $past(s_q.sdiv) - 4'h1;
  endproperty
  a_reload_wrap: assert property (p_reload_wrap) else $error("ratio loaded early");

endmodule : pcd_clock_ctl

// ---- verif/pcd_partner_model.sv ----
// Purpose: external core regulator and free running input clock source
// Assumes: power good follows wake after RAMP_CYCLES core_clk cycles
// Notes:   power good drops one edge after wake falls
module pcd_partner_model #(
  parameter int RAMP_CYCLES = 20         // regulator startup, in cycles
) (
  input  wire logic core_clk,            // bench clock
  input  wire logic regulator_wake_out,  // power request from device
  output logic      clock_input,         // free running input clock
  output logic      power_good_n         // supply good, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned ramp_q = 0;

  // ----------------------------------------------------------------
  // input clock, 200 ns period, phase apart from core_clk
  // ----------------------------------------------------------------
  initial begin
    clock_input = 1'b0;
    #7;
    forever #100 clock_input = ~clock_input;
  end

  // regulator ramp: restarts whenever wake is removed
  always @(posedge core_clk) begin
    if (!regulator_wake_out) ramp_q <= 0;
    else if (ramp_q < RAMP_CYCLES) ramp_q <= ramp_q + 1;
  end
  assign power_good_n = (ramp_q < RAMP_CYCLES);  // high until supply settles
endmodule : pcd_partner_model

// ---- verif/pll_clock_divider_and_regulator_wake_tb_top.sv ----
// Purpose: register level tests of the clock divider and wake block
// Assumes: core_clk stands for the vco; relock shortened to 4 cycles
// Notes:   tick periods are measured in core_clk cycles
module pll_clock_divider_and_regulator_wake_tb_top import pcd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        clock_input, power_good_n, buffered_clock_out, core_clock;
  logic        sysclk_tick, sysclk_echo_out, regulator_wake_out, device_run;
  logic        prev_ci = 1'b0;
  logic [6:0]  pll_mult;
  int          miscompares = 0;
  int          cmp_count = 0;
  logic [3:0]  ssel_tbl [4] = '{4'h1, 4'h2, 4'ha, 4'hf};
  logic [6:0]  mult_tbl [4] = '{7'h04, 7'h0a, 7'h41, 7'h40};
  logic [6:0]  mult_exp [4] = '{7'h06, 7'h0a, 7'h0a, 7'h40};

  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) prev_ci <= clock_input;

  pcd_clock_ctl #(.LOCK_CYCLES(4)) pcd_clock_ctl_inst (
    .core_clk(core_clk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .clock_input(clock_input),
    .power_good_n(power_good_n), .buffered_clock_out(buffered_clock_out),
    .core_clock(core_clock), .sysclk_tick(sysclk_tick),
    .sysclk_echo_out(sysclk_echo_out), .regulator_wake_out(regulator_wake_out),
    .device_run(device_run), .pll_mult(pll_mult));

  pcd_partner_model pcd_partner_model_inst (
    .core_clk(core_clk), .regulator_wake_out(regulator_wake_out),
    .clock_input(clock_input), .power_good_n(power_good_n));

  // ----------------------------------------------------------------
  // compare, bus and measurement tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // axi write: address and data offered together, response checked
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    r = 2'h3;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    chk(32'(r), 32'(er));
  endtask : wr

  // axi read: data taken at the edge where rvalid is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    r = 2'h3;
    d = 32'hdead_beef;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        r = rresp;
        d = rdata;
        rready <= 1'b0;
        break;
      end
    end
    chk(32'(r), 32'(er));
  endtask : rd

  function automatic logic pick(input int w);
    return (w == 0) ? core_clock : (w == 1) ? sysclk_tick : sysclk_echo_out;
  endfunction : pick

  task automatic to_tick(input int w);
    for (int n = 0; n < 100; n++) begin
      @(posedge core_clk);
      #1;
      if (pick(w) === 1'b1) break;
    end
  endtask : to_tick

  // distance between two ticks, after one full period at the new ratio
  task automatic period(input int w, output int p);
    realtime t0;
    to_tick(w);
    to_tick(w);
    t0 = $realtime;
    to_tick(w);
    p = int'(($realtime - t0) / 25.0);
  endtask : period

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    int p;
    int c;
    logic [31:0] v;
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk(regulator_wake_out, 1'b1);
    chk(pll_mult, PCD_MULT_RST);
    chk(device_run, 1'b0);
    repeat (30) @(posedge core_clk);
    #1;
    chk(device_run, 1'b1);
    rd(PCD_OFS_DIV, v, PCD_RESP_OK);
    chk(v[5:0], {PCD_CDF_RST, PCD_SSEL_RST});
    rd(PCD_OFS_MEMCTL, v, PCD_RESP_OK);
    chk(v[1:0], 2'h3);
    rd(PCD_OFS_VRCTL, v, PCD_RESP_OK);
    chk(v[1:0], PCD_REGF_RST);
    rd(PCD_OFS_STAT, v, PCD_RESP_OK);
    chk({v[11:8], v[6:0]}, {4'hf, PCD_MULT_RST});
    rd(8'h14, v, PCD_RESP_SLV);
    wr(PCD_OFS_STAT, 32'h0, PCD_RESP_SLV);
    wr(8'h20, 32'h0, PCD_RESP_SLV);
    for (int n = 0; n < 24; n++) begin
      @(posedge core_clk);
      #1;
      chk(buffered_clock_out, prev_ci);
    end
    $display("test reset and map done");
    for (int i = 0; i < 4; i++) begin
      wr(PCD_OFS_DIV, {26'h0, 2'(i), ssel_tbl[i]}, PCD_RESP_OK);
      period(1, p);
      chk(p, ssel_tbl[i]);
      period(2, p);
      chk(p, ssel_tbl[i]);
      period(0, p);
      chk(p, 1 << i);
    end
    wr(PCD_OFS_DIV, 32'h0, PCD_RESP_OK);
    rd(PCD_OFS_DIV, v, PCD_RESP_OK);
    chk(v[3:0], 4'hf);
    $display("test dividers done");
    wr(PCD_OFS_PLLCTL, 32'h106, PCD_RESP_OK);
    period(1, p);
    chk(p, 8);
    period(0, p);
    chk(p, 8);
    wr(PCD_OFS_PLLCTL, 32'h6, PCD_RESP_OK);
    $display("test bypass done");
    for (int m = 0; m < 4; m++) begin
      wr(PCD_OFS_MEMCTL, 32'(m), PCD_RESP_OK);
      repeat (2) @(posedge core_clk);
      c = 0;
      repeat (40) begin
        @(posedge core_clk);
        #1;
        c += int'(sysclk_echo_out === 1'b1);
      end
      chk(c != 0, m != 0);
    end
    $display("test echo enables done");
    for (int i = 0; i < 4; i++) begin
      wr(PCD_OFS_PLLCTL, 32'h200 | 32'(mult_tbl[i]), PCD_RESP_OK);
      repeat (20) @(posedge core_clk);
      #1;
      chk(pll_mult, mult_exp[i]);
    end
    wr(PCD_OFS_PLLCTL, 32'h0a, PCD_RESP_OK);
    repeat (20) @(posedge core_clk);
    #1;
    chk(pll_mult, 7'h40);
    $display("test multiplier done");
    wr(PCD_OFS_VRCTL, 32'(PCD_REGF_OFF), PCD_RESP_OK);
    repeat (4) @(posedge core_clk);
    #1;
    chk(regulator_wake_out, 1'b0);
    chk(device_run, 1'b0);
    wr(PCD_OFS_VRCTL, 32'h3, PCD_RESP_OK);
    repeat (3) @(posedge core_clk);
    #1;
    chk(regulator_wake_out, 1'b1);
    chk(device_run, 1'b0);
    repeat (30) @(posedge core_clk);
    #1;
    chk(device_run, 1'b1);
    $display("test regulator done");
    report_and_stop();
  end

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    report_and_stop();
  end
endmodule : pll_clock_divider_and_regulator_wake_tb_top
